// >>> core/fmr_pkg.sv
package fmr_pkg;

    // register indices inside one chip; byte address is four times the index
    localparam logic [3:0] IDX_DATA    = 4'h0;
    localparam logic [3:0] IDX_RAMX_LO = 4'h2;
    localparam logic [3:0] IDX_HSHAKE  = 4'h4;
    localparam logic [3:0] IDX_ENERGY  = 4'h5;
    localparam logic [3:0] IDX_DETECT  = 4'h7;
    localparam logic [3:0] IDX_DTMF    = 4'ha;
    localparam logic [3:0] IDX_TONE    = 4'hb;
    localparam logic [3:0] IDX_ANALOG  = 4'hc;
    localparam logic [3:0] IDX_EQ_RAMW = 4'hd;
    localparam logic [3:0] IDX_TXIRQ   = 4'he;
    localparam logic [3:0] IDX_ACCESS  = 4'hf;

    // bus address: bit 6 selects chip 0, bits 5:2 the index
    localparam int ADDR_W   = 8;
    localparam int CHIP_BIT = 6;

    // field positions
    localparam int B_IA     = 7;
    localparam int B_EYE    = 6;
    localparam int B_PATH   = 3;
    localparam int B_IE     = 2;
    localparam int B_AUDIO  = 1;
    localparam int B_MDA    = 0;
    localparam int B_PDM    = 7;
    localparam int B_FREEZE = 1;
    localparam int B_RAMW   = 0;
    localparam int B_RXO    = 7;
    localparam int B_SETUP  = 6;
    localparam int B_HDLC_FLAG_DETECT_ENABLE   = 5;
    localparam int B_LEVEL  = 1;
    localparam int B_FR1    = 5;
    localparam int B_PN     = 6;
    localparam int B_FLAG   = 5;
    localparam int B_RING   = 4;
    localparam int B_CARRIER_DETECT_STATUS   = 0;
    localparam int B_FED    = 6;
    localparam int B_P2     = 2;
    localparam int B_PARALLEL_CLEAR_TO_SEND   = 1;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ring debounce length in cycles
    localparam int DEBOUNCE_CYCLES = 1000;

    // transmit output routing
    typedef enum logic [1:0] {
        PATH_MODEM,
        PATH_AUX,
        PATH_SUM,
        PATH_SQUELCH
    } fmr_path_e;

    // analog section settings, applied together
    typedef struct packed {
        logic      eye;
        logic      rx_ground;
        logic      audio;
        fmr_path_e path;
        logic [3:0] atten;
    } fmr_analog_s;

    localparam fmr_analog_s ANALOG_RST = '{1'b0, 1'b0, 1'b0, PATH_SUM, 4'h0};

    // detector results from the signal-processing core
    typedef struct packed {
        logic [2:0] tone;
        logic [7:0] dtmf;
        logic       pn_detect;
        logic       pn_start;
        logic       pn_end;
        logic       p2_detect;
        logic       flag_event;
        logic       carrier_n;
        logic       energy_n;
        logic       group2_tx;
        logic [7:0] ram_x_low;
    } fmr_stat_s;

endpackage

// >>> core/fmr_debounce.sv
`timescale 1ns/100ps
`default_nettype none
module fmr_debounce
    import fmr_pkg::*;
#(
    parameter int CYCLES = DEBOUNCE_CYCLES
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // level in and filtered level out
    input  wire logic raw,
    output var  logic stable
);

    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] count;

    // the output follows only after the input held a new level for CYCLES
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count  <= '0;
            stable <= 1'b0;
        end else if (raw == stable) begin
            count <= '0;
        end else if (count == CW'(CYCLES - 1)) begin
            count  <= '0;
            stable <= raw;
        end else begin
            count <= count + 1'b1;
        end
    end

endmodule
`default_nettype wire

// >>> core/fmr_regbank.sv
`timescale 1ns/100ps
`default_nettype none
module fmr_regbank
    import fmr_pkg::*;
#(
    parameter int RING_DEBOUNCE = DEBOUNCE_CYCLES
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write address and data
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output var  logic              awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output var  logic              wready,
    // axi4-lite write response
    output var  logic [1:0]        bresp,
    output var  logic              bvalid,
    input  wire logic              bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output var  logic              arready,
    output var  logic [31:0]       rdata,
    output var  logic [1:0]        rresp,
    output var  logic              rvalid,
    input  wire logic              rready,
    // core data exchange
    input  wire logic              core_wr0,
    input  wire logic              core_rd0,
    input  wire logic [7:0]        core_din0,
    input  wire logic              core_wr1,
    input  wire logic [7:0]        core_din1,
    output var  logic [7:0]        host_dout0,
    // core detector results
    input  wire fmr_stat_s         stat,
    // pins from the line side
    input  wire logic              ring_indicate,
    input  wire logic              cts_pin_n,
    // controls to the core and analog section
    output var  fmr_analog_s       analog,
    output var  logic              freeze_equalizer,
    output var  logic              hdlc_flag_detect_enable,
    output var  logic              parallel_data_select,
    output var  logic [6:0]        sample_access_code,
    output var  logic [7:0]        baud_access_code,
    output var  logic              baud_chip_ram_write,
    output var  logic              diag0_req,
    output var  logic              diag1_req,
    // shared interrupt line
    output var  logic              irq_n
);

    // true when the address names a register of this bank
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        logic [3:0] i;
        i = a[5:2];
        if (a[ADDR_W-1]) begin
            return 1'b0;
        end else if (a[CHIP_BIT]) begin
            return i inside {IDX_DATA, IDX_TXIRQ, IDX_ACCESS};
        end else begin
            return i inside {IDX_DATA, IDX_RAMX_LO, IDX_HSHAKE, IDX_ENERGY,
                IDX_DETECT, IDX_DTMF, IDX_TONE, IDX_ANALOG, IDX_EQ_RAMW,
                IDX_TXIRQ, IDX_ACCESS};
        end
    endfunction

    // true when the address names one given register
    function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                    input logic c, input logic [3:0] i);
        return a[ADDR_W-1] == 1'b0 && a[CHIP_BIT] == c && a[5:2] == i;
    endfunction

    logic        w_hs;
    logic        r_hs;
    logic        wr_ok;
    logic [7:0]  wb;
    logic        host_rw0;
    logic        host_rd1;
    logic        host_rd_det;
    logic        sample_chip_data_avail;
    logic        baud_chip_data_avail;
    logic        ie0;
    logic        ie1;
    logic        irq0;
    logic        irq1;
    logic        eye;
    fmr_path_e   path;
    logic        audio;
    logic        receive_input_ground;
    logic [3:0]  level;
    logic        setup_pend;
    logic [7:0]  data1;
    logic [1:0]  pin_meta;
    logic [1:0]  pin_sync;
    logic        ring_clean;
    logic        flag_bit;
    logic        pn_bit;
    logic        p2_bit;
    logic [2:0]  tone_bits;
    logic [7:0]  dtmf_bits;
    logic        ring_bit;
    logic        parallel_clear_to_send_bit;
    logic        carrier_detect_status_bit;
    logic        fed_bit;
    logic [7:0]  next_rdata;

    // bus handshakes and register strobes
    assign w_hs        = awready & awvalid;
    assign r_hs        = arready & arvalid;
    assign wr_ok       = w_hs & wstrb[0] & mapped(awaddr);
    assign wb          = wdata[7:0];
    assign host_rw0    = (wr_ok & is_reg(awaddr, 1'b1, IDX_DATA))
                       | (r_hs & is_reg(araddr, 1'b1, IDX_DATA));
    assign host_rd1    = r_hs & is_reg(araddr, 1'b0, IDX_DATA);
    assign host_rd_det = r_hs & is_reg(araddr, 1'b0, IDX_DETECT);

    // write address and data are taken together, one write at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready  <= 1'b0;
        end else begin
            awready <= awvalid & wvalid & ~awready & ~bvalid;
            wready  <= awvalid & wvalid & ~awready & ~bvalid;
        end
    end

    // write response, error for an unmapped address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (w_hs) begin
            bvalid <= 1'b1;
            bresp  <= mapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // read address acceptance, one read at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
        end else begin
            arready <= arvalid & ~arready & ~rvalid;
        end
    end

    // read data selection, zero above bit 7 and for holes
    always_comb begin
        next_rdata = 8'h00;
        if (araddr[CHIP_BIT]) begin
            unique case (araddr[5:2])
                IDX_DATA:   next_rdata = host_dout0;
                IDX_TXIRQ:  next_rdata = {irq0, 4'h0, ie0, 1'b0, sample_chip_data_avail};
                IDX_ACCESS: next_rdata = {parallel_data_select, sample_access_code};
                default:    next_rdata = 8'h00;
            endcase
        end else begin
            unique case (araddr[5:2])
                IDX_DATA:    next_rdata = data1;
                IDX_RAMX_LO: next_rdata = stat.ram_x_low;
                IDX_HSHAKE:  next_rdata = {5'h00, p2_bit, parallel_clear_to_send_bit, 1'b0};
                IDX_ENERGY:  next_rdata = {1'b0, fed_bit, 6'h00};
                IDX_DETECT:  next_rdata = {1'b0, pn_bit, flag_bit, ring_bit,
                                           3'h0, carrier_detect_status_bit};
                IDX_DTMF:    next_rdata = dtmf_bits;
                IDX_TONE:    next_rdata = {tone_bits, 5'h00};
                IDX_ANALOG:  next_rdata = {receive_input_ground, setup_pend, hdlc_flag_detect_enable,
                                           level, 1'b0};
                IDX_EQ_RAMW: next_rdata = {6'h00, freeze_equalizer, baud_chip_ram_write};
                IDX_TXIRQ:   next_rdata = {irq1, eye, 1'b0, path, ie1, audio, baud_chip_data_avail};
                IDX_ACCESS:  next_rdata = baud_access_code;
                default:     next_rdata = 8'h00;
            endcase
        end
        if (!mapped(araddr)) begin
            next_rdata = 8'h00;
        end
    end

    // read response holds until the master takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rresp  <= RESP_OKAY;
            rdata  <= 32'h0000_0000;
        end else if (r_hs) begin
            rvalid <= 1'b1;
            rresp  <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata  <= {24'h00_0000, next_rdata};
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // chip-0 data register, shared by host and core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_dout0 <= 8'h00;
        end else if (wr_ok && is_reg(awaddr, 1'b1, IDX_DATA)) begin
            host_dout0 <= wb;
        end else if (core_wr0) begin
            host_dout0 <= core_din0;
        end
    end

    // chip-1 data register, written only by the core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data1 <= 8'h00;
        end else if (core_wr1) begin
            data1 <= core_din1;
        end
    end

    // data-available flags; a core event wins over a host clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_chip_data_avail <= 1'b0;
            baud_chip_data_avail <= 1'b0;
        end else begin
            if (core_wr0 || core_rd0) begin
                sample_chip_data_avail <= 1'b1;
            end else if (host_rw0) begin
                sample_chip_data_avail <= 1'b0;
            end
            if (core_wr1) begin
                baud_chip_data_avail <= 1'b1;
            end else if (host_rd1) begin
                baud_chip_data_avail <= 1'b0;
            end
        end
    end

    // chip-0 interrupt enable, parallel mode and access code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ie0                  <= 1'b0;
            parallel_data_select <= 1'b0;
            sample_access_code   <= 7'h00;
        end else if (wr_ok && awaddr[CHIP_BIT]) begin
            if (awaddr[5:2] == IDX_TXIRQ) begin
                ie0 <= wb[B_IE];
            end
            if (awaddr[5:2] == IDX_ACCESS) begin
                parallel_data_select <= wb[B_PDM];
                sample_access_code   <= wb[6:0];
            end
        end
    end

    // chip-1 control fields written by the host
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ie1                     <= 1'b0;
            eye                     <= ANALOG_RST.eye;
            path                    <= ANALOG_RST.path;
            audio                   <= ANALOG_RST.audio;
            receive_input_ground                     <= ANALOG_RST.rx_ground;
            level                   <= ANALOG_RST.atten;
            hdlc_flag_detect_enable <= 1'b0;
            freeze_equalizer        <= 1'b0;
            baud_chip_ram_write     <= 1'b0;
            baud_access_code        <= 8'h00;
        end else if (wr_ok && !awaddr[CHIP_BIT]) begin
            unique case (awaddr[5:2])
                IDX_TXIRQ: begin
                    ie1   <= wb[B_IE];
                    eye   <= wb[B_EYE];
                    path  <= fmr_path_e'(wb[B_PATH+:2]);
                    audio <= wb[B_AUDIO];
                end
                IDX_ANALOG: begin
                    receive_input_ground                     <= wb[B_RXO];
                    hdlc_flag_detect_enable <= wb[B_HDLC_FLAG_DETECT_ENABLE];
                    level                   <= wb[B_LEVEL+:4];
                end
                IDX_EQ_RAMW: begin
                    freeze_equalizer    <= wb[B_FREEZE];
                    baud_chip_ram_write <= wb[B_RAMW];
                end
                IDX_ACCESS: baud_access_code <= wb;
                default: ;
            endcase
        end
    end

    // setup strobe: set by the host, applied and cleared one cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            setup_pend <= 1'b0;
            analog     <= ANALOG_RST;
        end else begin
            if (setup_pend) begin
                analog.eye       <= eye;
                analog.rx_ground <= receive_input_ground;
                analog.audio     <= audio;
                analog.path      <= path;
                analog.atten     <= level;
            end
            if (wr_ok && is_reg(awaddr, 1'b0, IDX_ANALOG) && wb[B_SETUP]) begin
                setup_pend <= 1'b1;
            end else if (setup_pend) begin
                setup_pend <= 1'b0;
            end
        end
    end

    // diagnostic RAM requests follow an access-code write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            diag0_req <= 1'b0;
            diag1_req <= 1'b0;
        end else begin
            // a chip-0 fetch is withheld while parallel mode is chosen
            diag0_req <= wr_ok && is_reg(awaddr, 1'b1, IDX_ACCESS)
                         && !wb[B_PDM];
            // direction comes from the RAM-write bit the host set first
            diag1_req <= wr_ok && is_reg(awaddr, 1'b0, IDX_ACCESS);
        end
    end

    // interrupt drive per chip and the shared active-low line
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq0  <= 1'b0;
            irq1  <= 1'b0;
            irq_n <= 1'b1;
        end else begin
            irq0  <= ie0 & sample_chip_data_avail;
            irq1  <= ie1 & baud_chip_data_avail;
            irq_n <= ~((ie0 & sample_chip_data_avail) | (ie1 & baud_chip_data_avail));
        end
    end

    // two-flop synchronisers for the ring and clear-to-send pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta <= 2'b10;
            pin_sync <= 2'b10;
        end else begin
            pin_meta <= {cts_pin_n, ring_indicate};
            pin_sync <= pin_meta;
        end
    end

    // ring filter: level must hold steady before it is believed
    fmr_debounce #(
        .CYCLES (RING_DEBOUNCE)
    ) u_ring (
        .aclk    (aclk),
        .aresetn (aresetn),
        .raw     (pin_sync[0]),
        .stable  (ring_clean)
    );

    // level status bits sampled from the core and pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ring_bit  <= 1'b0;
            parallel_clear_to_send_bit  <= 1'b0;
            carrier_detect_status_bit  <= 1'b1;
            fed_bit   <= 1'b1;
            tone_bits <= 3'h0;
            dtmf_bits <= 8'h00;
        end else begin
            ring_bit  <= ring_clean;
            parallel_clear_to_send_bit  <= ~pin_sync[1];
            carrier_detect_status_bit  <= stat.carrier_n;
            fed_bit   <= stat.energy_n | stat.group2_tx;
            // first detector is off in group 2 transmit
            tone_bits <= {stat.tone[2:1], stat.tone[0] & ~stat.group2_tx};
            dtmf_bits <= stat.dtmf;
        end
    end

    // sequence bits: detection clears, sequence boundary sets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pn_bit <= 1'b1;
            p2_bit <= 1'b1;
        end else begin
            if (stat.pn_detect) begin
                pn_bit <= 1'b0;
            end else if (stat.pn_end) begin
                pn_bit <= 1'b1;
            end
            if (stat.p2_detect) begin
                p2_bit <= 1'b0;
            end else if (stat.pn_start) begin
                p2_bit <= 1'b1;
            end
        end
    end

    // flag status: held until read, cleared while flag detect is disabled, a new flag wins over the read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_bit <= 1'b0;
        end else if (!hdlc_flag_detect_enable) begin
            flag_bit <= 1'b0;
        end else if (stat.flag_event) begin
            flag_bit <= 1'b1;
        end else if (host_rd_det) begin
            flag_bit <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// >>> tb/fmr_regbank_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module fmr_regbank_monitor
    import fmr_pkg::*;
#(
    parameter int RING_DEBOUNCE = DEBOUNCE_CYCLES
) (
    // clock and reset
    input wire logic              aclk,
    input wire logic              aresetn,
    // write side
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [31:0]       wdata,
    input wire logic [3:0]        wstrb,
    input wire logic              awready,
    input wire logic              bvalid,
    input wire logic              bready,
    // read side
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic              arready,
    input wire logic [31:0]       rdata,
    input wire logic [1:0]        rresp,
    input wire logic              rvalid,
    input wire logic              rready,
    // controls
    input wire fmr_analog_s       analog,
    input wire logic              parallel_data_select,
    input wire logic              diag0_req,
    input wire logic              diag1_req
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // take edge of a write that carries the setup strobe
    wire logic st_tk = awready && wstrb[0] && awaddr == 8'h30 && wdata[6];
    property p_bans;
        awready |=> bvalid && !awready;
    endproperty
    a_bans: assert property (p_bans) else $error("write answer missing");
    property p_bdone;
        bvalid && bready |=> !bvalid;
    endproperty
    a_bdone: assert property (p_bdone) else $error("write answer not released");
    property p_rdone;
        rvalid && rready |=> !rvalid;
    endproperty
    a_rdone: assert property (p_rdone) else $error("read answer not released");
    property p_hole;
        arready && araddr == 8'h04 |=> rvalid && rresp == RESP_SLVERR && rdata == 32'h0;
    endproperty
    a_hole: assert property (p_hole) else $error("hole read not refused");
    property p_code;
        awready && wstrb[0] && awaddr == 8'h3c |=> diag1_req;
    endproperty
    a_code: assert property (p_code) else $error("access code request missing");
    property p_pdm;
        awready && wstrb[0] && awaddr == 8'h7c && wdata[7] |=> parallel_data_select && !diag0_req;
    endproperty
    a_pdm: assert property (p_pdm) else $error("parallel mode not blocking");
    property p_diag0;
        awready && wstrb[0] && awaddr == 8'h7c && !wdata[7] |=> diag0_req;
    endproperty
    a_diag0: assert property (p_diag0) else $error("diagnostic fetch missing");
    property p_apply;
        st_tk |-> ##2 analog.atten == $past(wdata[4:1], 2)
            && analog.rx_ground == $past(wdata[7], 2);
    endproperty
    a_apply: assert property (p_apply) else $error("setup not applied");
    property p_hold;
        $changed(analog) |-> $past(st_tk, 2);
    endproperty
    a_hold: assert property (p_hold) else $error("analog moved without setup");
endmodule
bind fmr_regbank fmr_regbank_monitor #(.RING_DEBOUNCE(RING_DEBOUNCE)) u_mon (
    .aclk, .aresetn, .awaddr, .wdata, .wstrb, .awready, .bvalid, .bready, .araddr,
    .arready, .rdata, .rresp, .rvalid, .rready, .analog, .parallel_data_select,
    .diag0_req, .diag1_req
);
`default_nettype wire

// >>> tb/fmr_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module fmr_core_model (
    // clock
    input  wire logic       aclk,
    // core strobes and data
    output var  logic       core_wr0,
    output var  logic       core_rd0,
    output var  logic       core_wr1,
    output wire logic [7:0] core_din0,
    output wire logic [7:0] core_din1
);
    logic [7:0] held = 8'h00;
    // idle bus shows the inverse of the last byte so stale data never matches
    assign core_din0 = core_wr0 ? held : ~held;
    assign core_din1 = core_wr1 ? held : ~held;
    initial {core_wr0, core_rd0, core_wr1} = 3'b000;
    // one-cycle core access: 0 write chip 0, 1 read chip 0, 2 write chip 1
    task automatic access(input int k, input logic [7:0] d);
        @(posedge aclk);
        held <= d;
        {core_wr0, core_rd0, core_wr1} <= {k == 0, k == 1, k == 2};
        @(posedge aclk);
        {core_wr0, core_rd0, core_wr1} <= 3'b000;
    endtask
endmodule
`default_nettype wire

// >>> tb/fmr_regbank_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module fmr_regbank_tb_top;
    import fmr_pkg::*;
    localparam int RING = 4;
    logic aclk = 1'b0, aresetn = 1'b0, ring_indicate = 1'b0, cts_pin_n = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rv;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] rsp, p;
    logic [3:0] at;
    fmr_stat_s stat;
    int mismatches = 0, n_checks = 0;
    wire logic awready, wready, bvalid, arready, rvalid, irq_n, core_wr0, core_rd0, core_wr1;
    wire logic parallel_data_select, freeze_equalizer, baud_chip_ram_write;
    wire logic hdlc_flag_detect_enable;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0] core_din0, core_din1, host_dout0, baud_access_code;
    wire logic [6:0] sample_access_code;
    wire fmr_analog_s analog;
    // 100 MHz clock
    always #5 aclk = ~aclk;
    fmr_core_model u_fmr_core_model (.aclk, .core_wr0, .core_rd0, .core_wr1, .core_din0,
        .core_din1);
    fmr_regbank #(.RING_DEBOUNCE(RING)) u_fmr_regbank (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .core_wr0, .core_rd0, .core_din0, .core_wr1, .core_din1, .host_dout0,
        .stat, .ring_indicate, .cts_pin_n, .analog, .freeze_equalizer,
        .hdlc_flag_detect_enable, .parallel_data_select, .sample_access_code,
        .baud_access_code, .baud_chip_ram_write, .diag0_req(), .diag1_req(), .irq_n
    );
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // one edge of a bounded wait
    task automatic step(inout int n);
        @(posedge aclk);
        n++;
        if (n > 50) begin
            mismatches++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        logic got = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        {awvalid, wvalid, bready} <= 3'b111;
        while (!got) begin
            step(n);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            got = bvalid;
            rsp = bresp;
        end
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        int n = 0;
        logic got = 1'b0;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        while (!got) begin
            step(n);
            if (arready) arvalid <= 1'b0;
            got = rvalid;
            rv = rdata;
            rsp = rresp;
        end
        rready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(rv, {24'h0, e});
    endtask
    // one-cycle pulse on a status event bit
    task automatic ev(input int k);
        stat[k] <= 1'b1;
        tick(1);
        stat[k] <= 1'b0;
    endtask
    initial begin
        stat = '0;
        stat.carrier_n = 1'b1;
        stat.energy_n = 1'b1;
        tick(5);
        aresetn <= 1'b1;
        chk(32'(analog), 32'(ANALOG_RST));
        rc(8'h38, 8'h10);
        rc(8'h1c, 8'h41);
        rc(8'h14, 8'h40);
        rc(8'h10, 8'h04);
        wr(8'h38, 8'h14);
        u_fmr_core_model.access(2, 8'h5a);
        tick(2);
        chk(32'(irq_n), 32'h0);
        rc(8'h38, 8'h95);
        rc(8'h00, 8'h5a);
        rc(8'h38, 8'h14);
        chk(32'(irq_n), 32'h1);
        u_fmr_core_model.access(0, 8'h33);
        rc(8'h78, 8'h01);
        rc(8'h40, 8'h33);
        rc(8'h78, 8'h00);
        u_fmr_core_model.access(1, 8'h00);
        rc(8'h78, 8'h01);
        wr(8'h40, 8'h77);
        chk(32'(host_dout0), 32'h77);
        rc(8'h78, 8'h00);
        for (int i = 0; i < 4; i++) begin
            p = 2'(i);
            at = 4'(i * 5);
            wr(8'h38, {1'b0, p[0], 1'b0, p, 1'b0, p[1], 1'b0});
            if (i == 0) chk(32'(analog), 32'(ANALOG_RST));
            wr(8'h30, {p[0], 1'b1, 1'b0, at, 1'b0});
            // the strobe applies on the edge where the write response is seen
            tick(1);
            chk(32'(analog), {23'h0, p[0], p[0], p[1], p, at});
            rc(8'h30, {p[0], 2'b00, at, 1'b0});
        end
        wr(8'h7c, 8'h05);
        wr(8'h7c, 8'h85);
        chk(32'({parallel_data_select, sample_access_code}), 32'h85);
        wr(8'h34, 8'h03);
        chk(32'({freeze_equalizer, baud_chip_ram_write}), 32'h3);
        wr(8'h3c, 8'ha5);
        chk(32'(baud_access_code), 32'ha5);
        stat.tone <= 3'b111;
        rc(8'h2c, 8'he0);
        stat.group2_tx <= 1'b1;
        stat.energy_n <= 1'b0;
        rc(8'h2c, 8'hc0);
        rc(8'h14, 8'h40);
        stat.group2_tx <= 1'b0;
        rc(8'h14, 8'h00);
        stat.dtmf <= 8'h81;
        rc(8'h28, 8'h81);
        ev(15);
        rc(8'h1c, 8'h01);
        ev(13);
        rc(8'h1c, 8'h41);
        ev(12);
        rc(8'h10, 8'h00);
        ev(14);
        rc(8'h10, 8'h04);
        ev(11);
        rc(8'h1c, 8'h41);
        wr(8'h30, 8'h20);
        chk(32'(hdlc_flag_detect_enable), 32'h1);
        ev(11);
        rc(8'h1c, 8'h61);
        rc(8'h1c, 8'h41);
        ring_indicate <= 1'b1;
        cts_pin_n <= 1'b0;
        stat.carrier_n <= 1'b0;
        tick(RING + 4);
        rc(8'h1c, 8'h50);
        rc(8'h10, 8'h06);
        rd(8'h04);
        chk(32'(rsp), 32'(RESP_SLVERR));
        wr(8'h44, 8'hff);
        chk(32'(rsp), 32'(RESP_SLVERR));
        finish_test();
    end
endmodule
`default_nettype wire
